// File: src/bctc_regs.svh
`ifndef BCTC_REGS_SVH
`define BCTC_REGS_SVH

// Register offsets (byte addresses)
`define BCTC_OFF_SEC       8'h00
`define BCTC_OFF_MIN       8'h04
`define BCTC_OFF_HOUR      8'h08
`define BCTC_OFF_MDAY      8'h0C
`define BCTC_OFF_MON       8'h10
`define BCTC_OFF_YEAR      8'h14
`define BCTC_OFF_WDAY      8'h18
`define BCTC_OFF_ASEC      8'h20
`define BCTC_OFF_AMIN      8'h24
`define BCTC_OFF_AHOUR     8'h28
`define BCTC_OFF_AMDAY     8'h2C
`define BCTC_OFF_AMON      8'h30
`define BCTC_OFF_AYEAR     8'h34
`define BCTC_OFF_CTRL      8'h40
`define BCTC_OFF_STAT      8'h44
`define BCTC_OFF_INTCFG    8'h48
`define BCTC_OFF_KEY0      8'h6C
`define BCTC_OFF_KEY1      8'h70

// Control bits
`define BCTC_CTRL_RUN      0
`define BCTC_CTRL_HFMT     2
`define BCTC_CTRL_ROUND    3
`define BCTC_CTRL_SHUT     6
`define BCTC_CTRL_ISO      7
`define BCTC_CTRL_RST      8'h00

// Status bits
`define BCTC_STAT_BUSY     0
`define BCTC_STAT_RUN      1
`define BCTC_STAT_EVT      2
`define BCTC_STAT_ALM      6
`define BCTC_STAT_OPEN     7

// Interrupt configuration bits
`define BCTC_INT_PER_LSB   0
`define BCTC_INT_TMR       2
`define BCTC_INT_ALM       3
`define BCTC_INT_RST       4'h0

// Hour field
`define BCTC_HOUR_PM       7

// Unlock keys
`define BCTC_KEY0_VAL      32'h83E7_0B13
`define BCTC_KEY1_VAL      32'h95A4_F1E0

// BCD limits
`define BCTC_BCD_ZERO      8'h00
`define BCTC_BCD_FIRST     8'h01
`define BCTC_SEC_MAX       8'h59
`define BCTC_ROUND_HALF    8'h30
`define BCTC_HR24_MAX      8'h23
`define BCTC_HR12_MAX      8'h12
`define BCTC_HR_MORN_LAST  8'h11
`define BCTC_MON_MAX       8'h12
`define BCTC_YEAR_MAX      8'h99
`define BCTC_WDAY_MAX      3'h6

// Timing
`define BCTC_CLK_MHZ       25
`define BCTC_TICK_S        1
`define BCTC_BUSY_US       15
`define BCTC_WR_LAT        4

`endif

// File: src/bctc_pkg.sv
package bctc_pkg;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic       pm;
        logic [7:0] mday;
        logic [7:0] mon;
        logic [7:0] year;
        logic [2:0] wday;
    } bctc_time_t;

    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_FIRST  = 2'b01,
        KEY_OPEN   = 2'b10
    } bctc_lock_t;

endpackage

// File: src/bctc_core.sv
// The address map and the APB register port are this design's own decisions.
`include "bctc_regs.svh"

// Overview of operation
// - Counters advance once per second while running.
// - Seconds are BCD 00 to 59, wrap to 00 and carry to minutes.
// - Minutes are BCD 00 to 59, wrap and carry into hours.
// - Hours are BCD 01-12 in twelve-hour form, 00-23 in twenty-four-hour form.
// - Day of month runs 01 up to the current month's length.
// - Month runs BCD 01 to 12, January is 1.
// - Year runs BCD 00 to 99 and wraps to 00.
// - February has 29 days in leap years.
// - Weekday is 3 bits 0 to 6, Sunday 0, steps each day.
// - Alarm fields use the same BCD layout as the time fields.
// - Format bit 0 counts 00-23; afternoon flag unused, software keeps it clear.
// - Format bit 1 counts twelve-hour; afternoon flag 0 morning, 1 afternoon.
// - Seconds read snapshots all fields; other time-field reads return the snapshot.
// - Rounding bit makes next seconds read round to nearest minute, once.
// - Run bit clear stops all automatic counter updates.
// - Busy low only when no update follows within 15 us.
// - Time writes apply four cycles later; reads meanwhile return old data.
// - Shutdown bit stops the clock and cannot be cleared again.
// - Reset loads time 00:00:00 01-01-00 and clears control, so counting stops.
// - Alarm and periodic sources merge into one interrupt line.
// - Writes except to the two key registers are ignored while locked.
// - First key then second key unlocks; any later key write relocks.
// - Busy high means update within 15 us; busy falls after it.
// - Full alarm match sets alarm flag and interrupt; write 1 clears.
// - Periodic interrupt every second, minute, hour or day by field 0-3.
module bctc_core #(
    parameter int unsigned SEC_CYC = `BCTC_TICK_S * `BCTC_CLK_MHZ * 1000000
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             leakageIsolationEn
);

    localparam int unsigned BUSY_CYC = `BCTC_BUSY_US * `BCTC_CLK_MHZ;
    localparam logic [2:0]  WR_LAT   = 3'(`BCTC_WR_LAT);
    localparam logic [24:0] TICK_END = 25'(SEC_CYC - 1);
    localparam logic [24:0] BUSY_BEG = 25'(SEC_CYC - BUSY_CYC);

    bctc_pkg::bctc_time_t timeR;
    bctc_pkg::bctc_time_t stepT;
    bctc_pkg::bctc_time_t shadowR;
    bctc_pkg::bctc_time_t alarmR;
    bctc_pkg::bctc_lock_t lock_r;

    logic [7:0]  ctrl_r;
    logic [3:0]  intCfg_r;
    logic [3:0]  evt_r;
    logic        alarmFlag_r;
    logic [24:0] divCnt_r;
    logic [2:0]  pendCnt_r;
    logic [7:0]  pendAddr_r;
    logic [31:0] pendData_r;
    logic [31:0] prdata_r;
    logic        err_r;
    logic [31:0] rdData;
    logic        counting;
    logic        secTick;
    logic        busyFlag;
    logic        setupRd;
    logic        wrDone;
    logic        unlocked;
    logic        roundDo;
    logic        secStep;
    logic        applyWr;
    logic        alarmHit;
    logic        minC;
    logic        hrC;
    logic        dayC;
    logic        monC;
    logic        yrC;

    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcdInc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic [7:0] monthLen(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: monthLen = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: monthLen = 8'h30;
            default: monthLen = 8'h31;
        endcase
    endfunction

    function automatic logic isTimeReg(input logic [7:0] a);
        isTimeReg = (a <= `BCTC_OFF_WDAY) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = isTimeReg(a) || (a[1:0] == 2'b00 &&
                   ((a >= `BCTC_OFF_ASEC && a <= `BCTC_OFF_AYEAR) ||
                    (a >= `BCTC_OFF_CTRL && a <= `BCTC_OFF_INTCFG) ||
                    a == `BCTC_OFF_KEY0 || a == `BCTC_OFF_KEY1));
    endfunction

    assign counting           = ctrl_r[`BCTC_CTRL_RUN] && !ctrl_r[`BCTC_CTRL_SHUT];
    assign leakageIsolationEn = ctrl_r[`BCTC_CTRL_ISO];
    assign unlocked           = (lock_r == bctc_pkg::KEY_OPEN);
    assign setupRd            = psel && !penable && !pwrite;
    assign pready             = !pwrite || (pendCnt_r == 3'h0);
    assign wrDone             = psel && penable && pwrite && pready;
    assign pslverr            = psel && penable && err_r;
    assign prdata             = prdata_r;
    assign applyWr            = (pendCnt_r == 3'h1);
    assign roundDo            = setupRd && paddr == `BCTC_OFF_SEC && ctrl_r[`BCTC_CTRL_ROUND];
    assign secTick            = counting && divCnt_r == TICK_END;
    assign secStep            = secTick && !roundDo;
    assign busyFlag           = counting && divCnt_r >= BUSY_BEG;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_r <= 25'h0;
        end else if (secTick) begin
            divCnt_r <= 25'h0;
        end else if (counting) begin
            divCnt_r <= divCnt_r + 25'h1;
        end
    end

    // Carry chain for one second step or minute rounding
    always_comb begin
        stepT = timeR;
        minC  = 1'b0;
        hrC   = 1'b0;
        dayC  = 1'b0;
        monC  = 1'b0;
        yrC   = 1'b0;
        if (secStep) begin
            if (timeR.sec == `BCTC_SEC_MAX) begin
                stepT.sec = `BCTC_BCD_ZERO;
                minC      = 1'b1;
            end else begin
                stepT.sec = bcdInc(timeR.sec);
            end
        end
        if (roundDo) begin
            stepT.sec = `BCTC_BCD_ZERO;
            minC      = timeR.sec >= `BCTC_ROUND_HALF;
        end
        if (minC) begin
            if (timeR.min == `BCTC_SEC_MAX) begin
                stepT.min = `BCTC_BCD_ZERO;
                hrC       = 1'b1;
            end else begin
                stepT.min = bcdInc(timeR.min);
            end
        end
        if (hrC) begin
            if (ctrl_r[`BCTC_CTRL_HFMT]) begin
                if (timeR.hour == `BCTC_HR12_MAX) begin
                    stepT.hour = `BCTC_BCD_FIRST;
                end else begin
                    stepT.hour = bcdInc(timeR.hour);
                    if (timeR.hour == `BCTC_HR_MORN_LAST) begin
                        stepT.pm = !timeR.pm;
                        dayC     = timeR.pm;
                    end
                end
            end else if (timeR.hour == `BCTC_HR24_MAX) begin
                stepT.hour = `BCTC_BCD_ZERO;
                dayC       = 1'b1;
            end else begin
                stepT.hour = bcdInc(timeR.hour);
            end
        end
        if (dayC) begin
            stepT.wday = (timeR.wday == `BCTC_WDAY_MAX) ? 3'h0 : timeR.wday + 3'h1;
            if (timeR.mday == monthLen(timeR.mon, timeR.year)) begin
                stepT.mday = `BCTC_BCD_FIRST;
                monC       = 1'b1;
            end else begin
                stepT.mday = bcdInc(timeR.mday);
            end
        end
        if (monC) begin
            if (timeR.mon == `BCTC_MON_MAX) begin
                stepT.mon = `BCTC_BCD_FIRST;
                yrC       = 1'b1;
            end else begin
                stepT.mon = bcdInc(timeR.mon);
            end
        end
        if (yrC) begin
            stepT.year = (timeR.year == `BCTC_YEAR_MAX) ? `BCTC_BCD_ZERO : bcdInc(timeR.year);
        end
    end

    // time state is data; reset only gives simulation a start value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeR <= '{sec: `BCTC_BCD_ZERO, min: `BCTC_BCD_ZERO, hour: `BCTC_BCD_ZERO,
                       pm: 1'b0, mday: `BCTC_BCD_FIRST, mon: `BCTC_BCD_FIRST,
                       year: `BCTC_BCD_ZERO, wday: 3'h0};
        end else begin
            if (secStep || roundDo) begin
                timeR <= stepT;
            end
            // host write overrides a colliding update
            if (applyWr) begin
                case (pendAddr_r)
                    `BCTC_OFF_SEC:  timeR.sec  <= {1'b0, pendData_r[6:0]};
                    `BCTC_OFF_MIN:  timeR.min  <= {1'b0, pendData_r[6:0]};
                    `BCTC_OFF_HOUR: begin
                        timeR.hour <= {2'b00, pendData_r[5:0]};
                        timeR.pm   <= pendData_r[`BCTC_HOUR_PM];
                    end
                    `BCTC_OFF_MDAY: timeR.mday <= {2'b00, pendData_r[5:0]};
                    `BCTC_OFF_MON:  timeR.mon  <= {3'b000, pendData_r[4:0]};
                    `BCTC_OFF_YEAR: timeR.year <= pendData_r[7:0];
                    default:        timeR.wday <= pendData_r[2:0];
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pendCnt_r  <= 3'h0;
            pendAddr_r <= 8'h00;
            pendData_r <= 32'h0000_0000;
        end else if (wrDone && unlocked && isTimeReg(paddr)) begin
            pendCnt_r  <= WR_LAT;
            pendAddr_r <= paddr;
            pendData_r <= pwdata;
        end else if (pendCnt_r != 3'h0) begin
            pendCnt_r <= pendCnt_r - 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_r <= bctc_pkg::KEY_LOCKED;
        end else if (wrDone && (paddr == `BCTC_OFF_KEY0 || paddr == `BCTC_OFF_KEY1)) begin
            case (lock_r)
                bctc_pkg::KEY_FIRST: begin
                    if (paddr == `BCTC_OFF_KEY1 && pwdata == `BCTC_KEY1_VAL) begin
                        lock_r <= bctc_pkg::KEY_OPEN;
                    end else if (paddr == `BCTC_OFF_KEY0 && pwdata == `BCTC_KEY0_VAL) begin
                        lock_r <= bctc_pkg::KEY_FIRST;
                    end else begin
                        lock_r <= bctc_pkg::KEY_LOCKED;
                    end
                end
                default: begin
                    if (paddr == `BCTC_OFF_KEY0 && pwdata == `BCTC_KEY0_VAL) begin
                        lock_r <= bctc_pkg::KEY_FIRST;
                    end else begin
                        lock_r <= bctc_pkg::KEY_LOCKED;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r   <= `BCTC_CTRL_RST;
            intCfg_r <= `BCTC_INT_RST;
            alarmR   <= '0;
        end else begin
            if (roundDo) begin
                ctrl_r[`BCTC_CTRL_ROUND] <= 1'b0;
            end
            if (wrDone && unlocked) begin
                case (paddr)
                    `BCTC_OFF_CTRL: begin
                        ctrl_r <= pwdata[7:0];
                        ctrl_r[`BCTC_CTRL_SHUT] <= pwdata[`BCTC_CTRL_SHUT] ||
                                                   ctrl_r[`BCTC_CTRL_SHUT];
                    end
                    `BCTC_OFF_INTCFG: intCfg_r <= pwdata[3:0];
                    // alarm fields masked like time fields
                    `BCTC_OFF_ASEC:  alarmR.sec  <= {1'b0, pwdata[6:0]};
                    `BCTC_OFF_AMIN:  alarmR.min  <= {1'b0, pwdata[6:0]};
                    `BCTC_OFF_AHOUR: begin
                        alarmR.hour <= {2'b00, pwdata[5:0]};
                        alarmR.pm   <= pwdata[`BCTC_HOUR_PM];
                    end
                    `BCTC_OFF_AMDAY: alarmR.mday <= {2'b00, pwdata[5:0]};
                    `BCTC_OFF_AMON:  alarmR.mon  <= {3'b000, pwdata[4:0]};
                    `BCTC_OFF_AYEAR: alarmR.year <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    assign alarmHit = secStep && intCfg_r[`BCTC_INT_ALM] &&
                      stepT.sec == alarmR.sec && stepT.min == alarmR.min &&
                      stepT.hour == alarmR.hour && stepT.pm == alarmR.pm &&
                      stepT.mday == alarmR.mday && stepT.mon == alarmR.mon &&
                      stepT.year == alarmR.year;

    // sticky alarm flag, set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarmFlag_r <= 1'b0;
        end else if (alarmHit) begin
            alarmFlag_r <= 1'b1;
        end else if (wrDone && unlocked && paddr == `BCTC_OFF_STAT &&
                     pwdata[`BCTC_STAT_ALM]) begin
            alarmFlag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_r <= 4'h0;
        end else if (!intCfg_r[`BCTC_INT_TMR]) begin
            evt_r <= 4'h0;
        end else if (secStep) begin
            evt_r <= {dayC, hrC, minC, 1'b1};
        end
    end

    assign irq = (intCfg_r[`BCTC_INT_ALM] && alarmFlag_r) ||
                 (intCfg_r[`BCTC_INT_TMR] && evt_r[intCfg_r[1:0]]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadowR <= '0;
        end else if (setupRd && paddr == `BCTC_OFF_SEC) begin
            shadowR <= roundDo ? stepT : timeR;
        end
    end

    always_comb begin
        rdData = 32'h0000_0000;
        case (paddr)
            `BCTC_OFF_SEC:    rdData[7:0] = roundDo ? stepT.sec : timeR.sec;
            `BCTC_OFF_MIN:    rdData[7:0] = shadowR.min;
            `BCTC_OFF_HOUR:   rdData[7:0] = {shadowR.pm, shadowR.hour[6:0]};
            `BCTC_OFF_MDAY:   rdData[7:0] = shadowR.mday;
            `BCTC_OFF_MON:    rdData[7:0] = shadowR.mon;
            `BCTC_OFF_YEAR:   rdData[7:0] = shadowR.year;
            `BCTC_OFF_WDAY:   rdData[2:0] = shadowR.wday;
            `BCTC_OFF_ASEC:   rdData[7:0] = alarmR.sec;
            `BCTC_OFF_AMIN:   rdData[7:0] = alarmR.min;
            `BCTC_OFF_AHOUR:  rdData[7:0] = {alarmR.pm, alarmR.hour[6:0]};
            `BCTC_OFF_AMDAY:  rdData[7:0] = alarmR.mday;
            `BCTC_OFF_AMON:   rdData[7:0] = alarmR.mon;
            `BCTC_OFF_AYEAR:  rdData[7:0] = alarmR.year;
            `BCTC_OFF_CTRL:   rdData[7:0] = ctrl_r;
            `BCTC_OFF_STAT:   rdData[7:0] = {unlocked, alarmFlag_r, evt_r, counting, busyFlag};
            `BCTC_OFF_INTCFG: rdData[3:0] = intCfg_r;
            default:          rdData = 32'h0000_0000;
        endcase
    end

    // Read data and error are latched in the setup phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
            err_r    <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rdData;
            err_r    <= !isMapped(paddr);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sec_wrap_a: assert property (secStep && timeR.sec == `BCTC_SEC_MAX && !applyWr
        |=> timeR.sec == `BCTC_BCD_ZERO) else $error("seconds did not wrap");
    min_carry_a: assert property (secStep && timeR.sec == `BCTC_SEC_MAX && !applyWr
        && timeR.min == `BCTC_SEC_MAX |=> timeR.min == `BCTC_BCD_ZERO)
        else $error("minutes did not wrap");
    hour24_wrap_a: assert property (hrC && !ctrl_r[`BCTC_CTRL_HFMT] && !applyWr
        && timeR.hour == `BCTC_HR24_MAX |=> timeR.hour == `BCTC_BCD_ZERO && $changed(timeR.wday))
        else $error("24h wrap wrong");
    noon_flip_a: assert property (hrC && ctrl_r[`BCTC_CTRL_HFMT] && !applyWr
        && timeR.hour == `BCTC_HR_MORN_LAST |=> timeR.hour == `BCTC_HR12_MAX
        && timeR.pm != $past(timeR.pm)) else $error("meridiem not toggled");
    busy_tick_a: assert property (secTick |-> busyFlag)
        else $error("update without busy");
    busy_fall_a: assert property ($fell(busyFlag) && counting |-> $past(secTick))
        else $error("busy fell without update");
    wr_delay_a: assert property (wrDone && unlocked && isTimeReg(paddr)
        |=> !applyWr [*3] ##1 applyWr) else $error("write applied at wrong cycle");
    stop_hold_a: assert property (!counting && !applyWr && !roundDo
        |=> $stable(timeR)) else $error("time changed while stopped");
    lock_block_a: assert property (wrDone && !unlocked && paddr == `BCTC_OFF_CTRL
        |=> $stable(ctrl_r)) else $error("locked write took effect");
    unlock_seq_a: assert property (wrDone && lock_r == bctc_pkg::KEY_FIRST
        && paddr == `BCTC_OFF_KEY1 && pwdata == `BCTC_KEY1_VAL |=> unlocked)
        else $error("unlock failed");
    alarm_flag_a: assert property (alarmHit |=> alarmFlag_r && irq)
        else $error("alarm not flagged");
    shut_keep_a: assert property (ctrl_r[`BCTC_CTRL_SHUT] |=> ctrl_r[`BCTC_CTRL_SHUT])
        else $error("shutdown cleared");

    day_wrap_c: cover property (dayC && secStep);
    unlock_c: cover property (lock_r == bctc_pkg::KEY_FIRST ##1 unlocked);
    alarm_c: cover property (alarmHit);
    round_c: cover property (roundDo && timeR.sec >= `BCTC_ROUND_HALF);

endmodule

// File: tb/bctc_core_bench.sv
`include "bctc_regs.svh"

module bctc_core_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned SEC_CYC = 1000;

    logic        clk = 1'b0;
    logic        rstN = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        leakIso;
    logic [31:0] q;
    logic        errSeen;
    int          mismatches = 0;
    int          checked = 0;

    always #20 clk = ~clk;

    bctc_core #(.SEC_CYC(SEC_CYC)) dut (
        .clk                (clk),
        .rst_n              (rstN),
        .paddr              (paddr),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .irq                (irq),
        .leakageIsolationEn (leakIso)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        q       = prdata;
        errSeen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Waits for busy to rise and fall once, i.e. one update
    task automatic tick();
        int n;
        for (int lvl = 1; lvl >= 0; lvl--) begin
            n = 0;
            do begin
                rd(`BCTC_OFF_STAT);
                n++;
            end while (q[`BCTC_STAT_BUSY] !== lvl[0] && n < 2000);
            if (n >= 2000) begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask

    function automatic logic [15:0] nextDate(input logic [7:0] mon, input logic [7:0] y);
        int v;
        v = y[7:4] * 10 + y[3:0];
        if (mon == 8'h12) return 16'h0101;
        return (v % 4 == 0) ? 16'h0229 : 16'h0301;
    endfunction

    initial begin
        int unsigned r;
        logic [7:0]  y;
        logic [7:0]  mon;
        logic [2:0]  w;
        logic        hm;
        logic [15:0] md;
        r = $urandom(22);
        repeat (12) @(posedge clk);
        rstN <= 1'b1;
        wr(`BCTC_OFF_CTRL, 32'h0000_0001);
        rd(`BCTC_OFF_CTRL);
        check("ctrl while locked", q, 32'h0000_0000);
        rd(8'hFC);
        check("unmapped error", {31'h0, errSeen}, 32'h0000_0001);
        wr(`BCTC_OFF_KEY0, `BCTC_KEY0_VAL);
        wr(`BCTC_OFF_KEY1, `BCTC_KEY1_VAL);
        rd(`BCTC_OFF_STAT);
        check("unlocked flag", {31'h0, q[`BCTC_STAT_OPEN]}, 32'h0000_0001);
        $display("test locking done");
        for (int i = 0; i < 4; i++) begin
            r   = $urandom % 100;
            y   = (i == 3) ? 8'h99 : 8'((r / 10) * 16 + r % 10);
            mon = (i == 3) ? 8'h12 : 8'h02;
            w   = 3'($urandom % 7);
            hm  = i[0];
            md  = nextDate(mon, y);
            // Counters stopped before setting the time
            wr(`BCTC_OFF_CTRL, hm ? 32'h0000_0004 : 32'h0000_0000);
            wr(`BCTC_OFF_SEC, 32'h0000_0059);
            wr(`BCTC_OFF_MIN, 32'h0000_0059);
            wr(`BCTC_OFF_HOUR, hm ? 32'h0000_0091 : 32'h0000_0023);
            wr(`BCTC_OFF_MDAY, (i == 3) ? 32'h0000_0031 : 32'h0000_0028);
            wr(`BCTC_OFF_MON, {24'h0, mon});
            wr(`BCTC_OFF_YEAR, {24'h0, y});
            wr(`BCTC_OFF_WDAY, {29'h0, w});
            wr(`BCTC_OFF_CTRL, hm ? 32'h0000_0005 : 32'h0000_0001);
            tick();
            wr(`BCTC_OFF_CTRL, 32'h0000_0000);
            rd(`BCTC_OFF_SEC);
            check("second wrap", q, 32'h0000_0000);
            rd(`BCTC_OFF_MIN);
            check("minute wrap", q, 32'h0000_0000);
            rd(`BCTC_OFF_HOUR);
            check("hour wrap", q, hm ? 32'h0000_0012 : 32'h0000_0000);
            rd(`BCTC_OFF_MDAY);
            check("day wrap", q, {24'h0, md[7:0]});
            rd(`BCTC_OFF_MON);
            check("month step", q, {24'h0, md[15:8]});
            rd(`BCTC_OFF_YEAR);
            check("year", q, (i == 3) ? 32'h0000_0000 : {24'h0, y});
            rd(`BCTC_OFF_WDAY);
            check("weekday step", q, 32'((w + 1) % 7));
        end
        $display("test calendar done");
        repeat (SEC_CYC + 50) @(posedge clk);
        rd(`BCTC_OFF_SEC);
        check("stopped second", q, 32'h0000_0000);
        wr(`BCTC_OFF_SEC, 32'h0000_0045);
        wr(`BCTC_OFF_MIN, 32'h0000_0010);
        wr(`BCTC_OFF_CTRL, 32'h0000_0008);
        rd(`BCTC_OFF_SEC);
        rd(`BCTC_OFF_SEC);
        check("rounded second", q, 32'h0000_0000);
        rd(`BCTC_OFF_MIN);
        check("rounded minute", q, 32'h0000_0011);
        wr(`BCTC_OFF_SEC, 32'h0000_0045);
        rd(`BCTC_OFF_SEC);
        check("old data after write", q, 32'h0000_0000);
        repeat (4) @(posedge clk);
        rd(`BCTC_OFF_SEC);
        check("rounding once", q, 32'h0000_0045);
        $display("test rounding done");
        // Alarm one second ahead of 12:11:45 01-01-00, every-second events on
        wr(`BCTC_OFF_ASEC, 32'h0000_0046);
        wr(`BCTC_OFF_AMIN, 32'h0000_0011);
        wr(`BCTC_OFF_AHOUR, 32'h0000_0012);
        wr(`BCTC_OFF_AMDAY, 32'h0000_0001);
        wr(`BCTC_OFF_AMON, 32'h0000_0001);
        wr(`BCTC_OFF_INTCFG, 32'h0000_000C);
        wr(`BCTC_OFF_CTRL, 32'h0000_0081);
        tick();
        wr(`BCTC_OFF_CTRL, 32'h0000_0080);
        check("irq on alarm", {31'h0, irq}, 32'h0000_0001);
        check("isolation enable", {31'h0, leakIso}, 32'h0000_0001);
        rd(`BCTC_OFF_STAT);
        check("alarm and second event", q, 32'h0000_00C4);
        wr(`BCTC_OFF_STAT, 32'h0000_0040);
        wr(`BCTC_OFF_INTCFG, 32'h0000_0008);
        rd(`BCTC_OFF_STAT);
        check("alarm cleared", q, 32'h0000_0080);
        check("irq released", {31'h0, irq}, 32'h0000_0000);
        wr(`BCTC_OFF_CTRL, 32'h0000_0040);
        wr(`BCTC_OFF_CTRL, 32'h0000_0001);
        rd(`BCTC_OFF_CTRL);
        check("shutdown sticky", q, 32'h0000_0041);
        rd(`BCTC_OFF_STAT);
        check("shutdown stops", q, 32'h0000_0080);
        $display("test alarm done");
        wr(`BCTC_OFF_KEY0, 32'h0000_0000);
        wr(`BCTC_OFF_CTRL, 32'h0000_0080);
        rd(`BCTC_OFF_CTRL);
        check("ctrl after relock", q, 32'h0000_0041);
        $display("test relock done");
        report_and_stop();
    end
endmodule
